// ==== src/prop_readout_port.sv ====
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
// What this block does
// RL1: Master drives line sync pin; slave uses it as input.
// RL2: Master drives frame sync pin; slave accepts it as input.
// RL3: Line and frame valid are high only around valid pixel data.
// RL4: Pixel data is stable at the rising pixel strobe clock edge.
// RL5: Output enable tristates only the ten data lines.
// RL6: Each pixel leaves as a ten-bit word, bit 0 least significant.
// RL7: Error output comes straight from the stereo error flag.
// RL8: Addressing covers a 782 by 492 physical array.
// RL9: Left 26 columns and top eight rows are black reference pixels.
// RL10: Black rows feed black level; middle four appear in raw mode.
// RL11: Active region 753 by 481 is addressed inside the array.
// RL12: Mirrored readout uses the extra column and row.
// RL13: Binning averages immediate neighbours only, mixing colours.
// RL14: Interlace fields split rows, giving red/green and blue/green fields.
// RL15: Colour bit uses first green pixels for black level; else all.
// RL16: Black and noise correction are identical for every colour.
// RL17: Exposure brightness uses all three colours.
// RL18: Controller should keep colour parts in linear mode.
// RL19: One ten-bit pixel per pixel clock period while line valid.
// RL20: Output enable is active high.
// RL21: Stereo role is latched while idle, stable during streaming.
module prop_readout_port
  import prop_pkg::*;
(
  input logic core_clk_in,
  input logic srst_in,
  input logic [7:0] reg_addr_in,
  input logic [31:0] reg_wdata_in,
  input logic reg_wr_in,
  input logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic [9:0] array_col_out,
  output logic [8:0] array_row_out,
  input logic [9:0] array_pix_in,
  input logic pixel_oe_in,
  output logic [9:0] pixel_data_out,
  output logic pixel_data_oe_n_out,
  output logic line_valid_out,
  output logic frame_valid_out,
  output logic pixel_strobe_clock_out,
  output logic error_out,
  input logic line_sync_pin_in,
  output logic line_sync_pin_out,
  output logic line_sync_pin_oe_n_out,
  input logic frame_sync_pin_in,
  output logic frame_sync_pin_out,
  output logic frame_sync_pin_oe_n_out
);

  prop_cfg_type ctrl_q;
  prop_cfg_type cfg_q;
  prop_state_type state_q;
  prop_state_type state_d;
  prop_stage_type stage_q;
  prop_stage_type stage_d;
  logic role_q;
  logic pix_clk_q;
  logic [9:0] hcnt_q;
  logic [9:0] hcnt_d;
  logic [8:0] seq_q;
  logic [8:0] seq_d;
  logic [5:0] vcnt_q;
  logic [5:0] vcnt_d;
  logic field_q;
  logic field_d;
  logic go_line;
  logic go_frame;
  logic frame_end;
  logic ls_prev_q;
  logic fs_prev_q;
  logic ls_pend_q;
  logic fs_pend_q;
  logic err_q;
  logic ls_drv_q;
  logic fs_drv_q;
  logic sync_oe_n_q;
  logic [9:0] col_q;
  logic [8:0] row_q;
  logic [9:0] first_q;
  logic [9:0] data_q;
  logic lv_q;
  logic fv_q;
  logic data_oe_n_q;
  logic [31:0] rdata_q;
  logic [28:0] bright_acc_q;
  logic [9:0] bright_q;
  logic [9:0] lv_len_q;
  logic [2:0] pins_s;
  logic [9:0] offset;

  // Pins from outside this clock domain pass two flops first.
  prop_sync2 #(.W(3)) u_pin_sync (
    .clk_in(core_clk_in),
    .srst_in(srst_in),
    .d_in({pixel_oe_in, line_sync_pin_in, frame_sync_pin_in}),
    .q_out(pins_s)
  );

  wire oe_s = pins_s[2];
  wire ls_s = pins_s[1];
  wire fs_s = pins_s[0];
  wire ls_rise = ls_s && !ls_prev_q;
  wire fs_rise = fs_s && !fs_prev_q;

  // The pixel strobe clock is the core clock halved; outputs move on
  // its falling edge so they are settled at the rising one.
  wire launch = pix_clk_q; // [RL4]

  // Row sequence: black rows first, then the active output rows.
  wire in_line = state_q == PROP_LINE;
  wire in_hblank = state_q == PROP_HBLANK;
  wire in_black = seq_q < BLACK_ROWS; // [RL9]
  wire [8:0] act_idx = seq_q - BLACK_ROWS;
  wire [8:0] rows_out = cfg_q.interlace ? FIELD_ROWS : OUT_ROWS;
  wire [8:0] seq_last = BLACK_ROWS + rows_out - 9'h001;
  wire [8:0] r_lin = cfg_q.interlace ? {act_idx[7:0], field_q} : act_idx; // [RL14]
  wire [8:0] row_act = cfg_q.mirror_row ? ROW_MIR_TOP - r_lin
                                        : BLACK_ROWS + r_lin; // [RL12]
  wire [8:0] row_a = in_black ? seq_q : row_act; // [RL11]

  // Columns; binning steps by two and reads the direct neighbour.
  wire [9:0] line_len = cfg_q.bin2 ? BIN_COLS : OUT_COLS;
  wire [9:0] c_lin = cfg_q.bin2 ? {hcnt_q[8:0], 1'b0} : hcnt_q; // [RL13]
  wire [9:0] col_ph = cfg_q.mirror_col ? COL_MIR_LEFT - c_lin
                                       : BLACK_COLS + c_lin; // [RL12]
  wire [9:0] col_nb = cfg_q.mirror_col ? col_q - 10'h001
                                       : col_q + 10'h001; // [RL13]

  // Black columns are sampled during the start of horizontal blanking.
  wire hbk_black = in_hblank && (hcnt_q < BLACK_COLS); // [RL9]
  // Vertical blanking counts past the array width, so its address parks at column 0.
  wire [9:0] col_a = in_line ? col_ph : in_hblank ? hcnt_q : 10'h000; // [RL8]
  wire raw_row = (seq_q >= RAW_FIRST) && (seq_q <= RAW_LAST);
  wire out_started = !in_black || (cfg_q.raw && seq_q >= RAW_FIRST);
  wire fv_span = in_line || (in_hblank && seq_q != seq_last);

  // Middle black rows go out only in raw mode.
  assign stage_d.valid = in_line && (!in_black || (cfg_q.raw && raw_row)); // [RL10]
  assign stage_d.fvwin = fv_span && out_started; // [RL3]
  assign stage_d.black = hbk_black || (in_line && in_black); // [RL10]
  assign stage_d.first_green_pixel = !row_a[0] && col_a[0];

  // Pair average for binning, then one offset for every colour.
  wire [10:0] pair_sum = {1'b0, first_q} + {1'b0, array_pix_in};
  wire [9:0] pix_val = cfg_q.bin2 ? pair_sum[10:1] : first_q; // [RL13]
  wire [10:0] diff = {1'b0, pix_val} - {1'b0, offset};
  wire [9:0] corr = diff[10] ? 10'h000 : diff[9:0]; // [RL16]
  wire [9:0] data_d = !stage_q.valid ? 10'h000
                    : stage_q.black ? pix_val : corr;

  // With the colour bit only first-green dark pixels are averaged.
  wire bl_sample = launch && stage_q.black
                && (!cfg_q.colour || stage_q.first_green_pixel); // [RL15]

  prop_black_level u_black (
    .clk_in(core_clk_in),
    .srst_in(srst_in),
    .restart_in(launch && go_frame),
    .sample_in(bl_sample),
    .pix_in(first_q),
    .offset_out(offset)
  );

  // Readout sequencer, advanced once per pixel period.
  always_comb begin
    state_d = state_q;
    hcnt_d = hcnt_q;
    seq_d = seq_q;
    vcnt_d = vcnt_q;
    field_d = field_q;
    go_line = 1'b0;
    go_frame = 1'b0;
    frame_end = 1'b0;
    unique case (state_q)
      PROP_IDLE: begin
        if (ctrl_q.enable) begin
          state_d = PROP_VBLANK;
          hcnt_d = 10'h000;
          vcnt_d = 6'h00;
        end
      end
      PROP_VBLANK: begin
        hcnt_d = (hcnt_q == ROW_TIME - 10'h001) ? 10'h000 : hcnt_q + 10'h001;
        if (hcnt_q == ROW_TIME - 10'h001 && vcnt_q != VBLANK_ROWS) begin
          vcnt_d = vcnt_q + 6'h01;
        end
        if (!ctrl_q.enable) begin
          state_d = PROP_IDLE;
        end else if (role_q ? vcnt_q == VBLANK_ROWS : fs_pend_q) begin // [RL2]
          state_d = PROP_LINE;
          hcnt_d = 10'h000;
          seq_d = 9'h000;
          go_frame = 1'b1;
          go_line = 1'b1;
        end
      end
      PROP_LINE: begin
        if (hcnt_q == line_len - 10'h001) begin
          state_d = PROP_HBLANK;
          hcnt_d = 10'h000;
        end else begin
          hcnt_d = hcnt_q + 10'h001; // [RL19]
        end
      end
      PROP_HBLANK: begin
        if (hcnt_q < HBLANK_LEN - 10'h001) begin
          hcnt_d = hcnt_q + 10'h001;
        end else if (seq_q == seq_last) begin
          state_d = PROP_VBLANK;
          hcnt_d = 10'h000;
          vcnt_d = 6'h00;
          field_d = cfg_q.interlace && !field_q; // [RL14]
          frame_end = 1'b1;
        end else if (role_q || ls_pend_q) begin // [RL1]
          state_d = PROP_LINE;
          hcnt_d = 10'h000;
          seq_d = seq_q + 9'h001;
          go_line = 1'b1;
        end
      end
      default: state_d = PROP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_q <= PROP_IDLE;
      hcnt_q <= 10'h000;
      seq_q <= 9'h000;
      vcnt_q <= 6'h00;
      field_q <= 1'b0;
    end else if (launch) begin
      state_q <= state_d;
      hcnt_q <= hcnt_d;
      seq_q <= seq_d;
      vcnt_q <= vcnt_d;
      field_q <= field_d;
    end
  end

  // The role only follows the control register while idle, so the sync
  // pin direction never flips in the middle of a stream.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      role_q <= 1'b0;
      cfg_q <= CTRL_RST;
    end else begin
      if (state_q == PROP_IDLE) begin
        role_q <= ctrl_q.master; // [RL21]
      end
      if (state_q == PROP_IDLE || (launch && go_frame)) begin
        cfg_q <= ctrl_q;
      end
    end
  end

  // Slave sync edges are held until the sequencer consumes them; a new
  // edge in the consuming cycle is kept.
  wire err_set = !role_q && ((ls_rise && in_line)
              || (fs_rise && (in_line || in_hblank))); // [RL7]
  wire err_clr = reg_wr_in && reg_addr_in == REG_STATUS
              && reg_wdata_in[STAT_ERR_BIT];

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ls_prev_q <= 1'b0;
      fs_prev_q <= 1'b0;
      ls_pend_q <= 1'b0;
      fs_pend_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ls_prev_q <= ls_s;
      fs_prev_q <= fs_s;
      ls_pend_q <= ls_rise || (ls_pend_q && !(launch && go_line)); // [RL1]
      fs_pend_q <= fs_rise || (fs_pend_q && !(launch && go_frame)); // [RL2]
      err_q <= err_set || (err_q && !err_clr);
    end
  end

  // Master sync pulses last one pixel period at each line and frame.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ls_drv_q <= 1'b0;
      fs_drv_q <= 1'b0;
      sync_oe_n_q <= 1'b1;
    end else begin
      sync_oe_n_q <= !role_q; // [RL1] [RL2]
      if (launch) begin
        ls_drv_q <= role_q && go_line; // [RL1]
        fs_drv_q <= role_q && go_frame; // [RL2]
      end
    end
  end

  // Address the pixel on the falling strobe edge, its neighbour after.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pix_clk_q <= 1'b0;
      col_q <= BLACK_COLS;
      row_q <= 9'h000;
      stage_q <= '0;
      first_q <= 10'h000;
    end else begin
      pix_clk_q <= !pix_clk_q;
      if (launch) begin
        col_q <= col_a; // [RL8]
        row_q <= row_a; // [RL8]
        stage_q <= stage_d;
      end else begin
        col_q <= col_nb;
        first_q <= array_pix_in;
      end
    end
  end

  // Output word, valids and the data-line enable, all from flops.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      data_q <= 10'h000;
      lv_q <= 1'b0;
      fv_q <= 1'b0;
      data_oe_n_q <= 1'b1;
      lv_len_q <= 10'h000;
    end else begin
      data_oe_n_q <= !oe_s; // [RL5] [RL20]
      if (launch) begin
        data_q <= data_d; // [RL6] [RL19]
        lv_q <= stage_q.valid; // [RL3]
        fv_q <= stage_q.fvwin; // [RL3]
        if (stage_q.valid) begin
          lv_len_q <= lv_q ? lv_len_q + 10'h001 : 10'h001;
        end
      end
    end
  end

  // Frame brightness over every colour, for exposure and gain loops.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      bright_acc_q <= 29'h00000000;
      bright_q <= 10'h000;
    end else if (launch && go_frame) begin
      bright_acc_q <= 29'h00000000;
    end else if (launch && frame_end) begin
      bright_q <= bright_acc_q[28] ? 10'h3ff : bright_acc_q[27:18];
    end else if (launch && stage_q.valid && !stage_q.black) begin
      bright_acc_q <= bright_acc_q + {19'h00000, corr}; // [RL17]
    end
  end

  // Register port; unmapped reads return zero.
  wire hit_ctrl = reg_addr_in == REG_CTRL;
  wire hit_stat = reg_addr_in == REG_STATUS;
  wire hit_black = reg_addr_in == REG_BLACK;
  wire hit_bright = reg_addr_in == REG_BRIGHT;
  wire [31:0] stat_word = {27'h0000000, fv_q, state_q != PROP_IDLE,
                           field_q, role_q, err_q};
  wire [31:0] rdata_d = hit_ctrl ? {24'h000000, ctrl_q}
                      : hit_stat ? stat_word
                      : hit_black ? {22'h000000, offset}
                      : hit_bright ? {22'h000000, bright_q}
                      : 32'h00000000;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ctrl_q <= CTRL_RST;
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= reg_rd_in ? rdata_d : 32'h00000000;
      if (reg_wr_in && hit_ctrl) begin
        ctrl_q <= reg_wdata_in[7:0];
      end
    end
  end

  assign reg_rdata_out = rdata_q;
  assign array_col_out = col_q;
  assign array_row_out = row_q;
  assign pixel_data_out = data_q;
  assign pixel_data_oe_n_out = data_oe_n_q;
  assign line_valid_out = lv_q;
  assign frame_valid_out = fv_q;
  assign pixel_strobe_clock_out = pix_clk_q;
  assign error_out = err_q; // [RL7]
  assign line_sync_pin_out = ls_drv_q;
  assign line_sync_pin_oe_n_out = sync_oe_n_q;
  assign frame_sync_pin_out = fs_drv_q;
  assign frame_sync_pin_oe_n_out = sync_oe_n_q;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  sequence slave_err_s;
    !role_q && ls_rise && in_line;
  endsequence

  sequence fs_pulse_s;
    (state_q == PROP_LINE && seq_q == 9'h000) ##1 fs_drv_q ##1 !fs_drv_q;
  endsequence

  lv_in_frame_a: assert property (lv_q |-> fv_q) // [RL3]
    else $error("Line valid outside frame valid.");

  data_stable_a: assert property ( // [RL4]
    !pix_clk_q |=> $stable(data_q) && $stable(lv_q))
    else $error("Pixel output moved at rising strobe edge.");

  oe_tristate_a: assert property ( // [RL5]
    $fell(oe_s) |=> data_oe_n_q && pix_clk_q != $past(pix_clk_q))
    else $error("Data enable not released or strobe stopped.");

  line_len_a: assert property ($fell(lv_q) |-> lv_len_q == line_len) // [RL19]
    else $error("Wrong number of pixels in a line.");

  err_flag_a: assert property (slave_err_s |=> error_out) // [RL7]
    else $error("Stereo error not flagged.");

  master_line_a: assert property ( // [RL1]
    $rose(ls_drv_q) |-> role_q && in_line && hcnt_q == 10'h000)
    else $error("Line sync pulse off line start.");

  slave_pins_a: assert property (!role_q |=> sync_oe_n_q) // [RL1]
    else $error("Slave drives sync pins.");

  master_frame_a: assert property ($rose(fs_drv_q) |-> fs_pulse_s) // [RL2]
    else $error("Frame sync pulse malformed.");

  addr_range_a: assert property ( // [RL8]
    col_q < ARRAY_COLS && row_q < ARRAY_ROWS)
    else $error("Address outside physical array.");

  active_win_a: assert property ( // [RL11]
    launch && in_line && !in_black |=> row_q > BLACK_ROWS - 9'h001
      && row_q < BLACK_ROWS + ACT_ROWS && col_q >= BLACK_COLS
      && col_q < BLACK_COLS + ACT_COLS)
    else $error("Active read outside active region.");

  mirror_start_a: assert property ( // [RL12]
    launch && in_line && !in_black && cfg_q.mirror_col && hcnt_q == 10'h000
      |=> col_q == COL_MIR_LEFT)
    else $error("Mirrored line starts on wrong column.");

endmodule

// ==== src/prop_pkg.sv ====
package prop_pkg;

  // Physical array geometry, pixel counts.
  localparam logic [9:0] ARRAY_COLS = 10'h30e;
  localparam logic [8:0] ARRAY_ROWS = 9'h1ec;
  localparam logic [9:0] BLACK_COLS = 10'h01a;
  localparam logic [8:0] BLACK_ROWS = 9'h008;
  localparam logic [9:0] ACT_COLS = 10'h2f1;
  localparam logic [8:0] ACT_ROWS = 9'h1e1;

  // Output window and the mirrored starting points one past it.
  localparam logic [9:0] OUT_COLS = 10'h2f0;
  localparam logic [9:0] BIN_COLS = 10'h178;
  localparam logic [8:0] OUT_ROWS = 9'h1e0;
  localparam logic [8:0] FIELD_ROWS = 9'h0f0;
  localparam logic [9:0] COL_MIR_LEFT = 10'h30a;
  localparam logic [8:0] ROW_MIR_TOP = 9'h1e8;
  localparam logic [8:0] RAW_FIRST = 9'h002;
  localparam logic [8:0] RAW_LAST = 9'h005;

  // Blanking in pixel periods and rows.
  localparam logic [9:0] HBLANK_LEN = 10'h05e;
  localparam logic [9:0] ROW_TIME = 10'h34e;
  localparam logic [5:0] VBLANK_ROWS = 6'h2d;

  // Black-level averaging window.
  localparam logic [8:0] BL_SAMPLES = 9'h100;

  // Register offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_BLACK = 8'h08;
  localparam logic [7:0] REG_BRIGHT = 8'h0c;
  localparam int STAT_ERR_BIT = 0;

  typedef enum logic [3:0] {
    PROP_IDLE = 4'h1,
    PROP_VBLANK = 4'h2,
    PROP_LINE = 4'h4,
    PROP_HBLANK = 4'h8
  } prop_state_type;

  typedef struct packed {
    logic interlace;
    logic bin2;
    logic mirror_row;
    logic mirror_col;
    logic raw;
    logic colour;
    logic master;
    logic enable;
  } prop_cfg_type;

  localparam prop_cfg_type CTRL_RST = 8'h00;

  typedef struct packed {
    logic valid;
    logic fvwin;
    logic black;
    logic first_green_pixel;
  } prop_stage_type;

endpackage

// ==== src/prop_sync2.sv ====
`timescale 1ns/1ns
module prop_sync2 #(
  parameter int W = 1
) (
  input logic clk_in,
  input logic srst_in,
  input logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_q;

  // Two stages; only the second stage is read by anyone.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta_q <= '0;
      q_out <= '0;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end

endmodule

// ==== src/prop_black_level.sv ====
`timescale 1ns/1ns
module prop_black_level
  import prop_pkg::*;
(
  input logic clk_in,
  input logic srst_in,
  input logic restart_in,
  input logic sample_in,
  input logic [9:0] pix_in,
  output logic [9:0] offset_out
);

  logic [17:0] sum_q;
  logic [8:0] cnt_q;
  wire [17:0] sum_next = sum_q + {8'h00, pix_in};
  wire take = sample_in && (cnt_q != BL_SAMPLES);

  // Averages a fixed number of dark samples per frame; a power of two
  // keeps the divide a plain slice. The old offset holds until done.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sum_q <= 18'h00000;
      cnt_q <= 9'h000;
      offset_out <= 10'h000;
    end else if (restart_in) begin
      sum_q <= 18'h00000;
      cnt_q <= 9'h000;
    end else if (take) begin
      sum_q <= sum_next;
      cnt_q <= cnt_q + 9'h001;
      if (cnt_q == BL_SAMPLES - 9'h001) begin
        offset_out <= sum_next[17:8];
      end
    end
  end

endmodule

// ==== sim/prop_grabber.sv ====
`timescale 1ns/1ns
// Receiver on the parallel pixel port, as a frame grabber would sit there.
module prop_grabber (
  input wire logic strobe_in,
  input wire logic [9:0] data_in,
  input wire logic line_valid_in,
  input wire logic frame_valid_in,
  output logic [11:0] words_out,
  output logic [9:0] first_out,
  output logic same_out,
  output logic fv_ok_out
);
  logic lv_q;

  // Start from an empty record so that a missing line is never taken for a good one.
  initial begin
    lv_q = 1'b0;
    words_out = 12'h000;
    first_out = 10'h000;
    same_out = 1'b0;
    fv_ok_out = 1'b1;
  end

  // The bus is latched only on the rising strobe; a tristated bus never matches.
  always @(posedge strobe_in) begin
    if (line_valid_in && !lv_q) begin
      words_out <= 12'h001;
      first_out <= data_in;
      same_out <= 1'b1;
    end else if (line_valid_in) begin
      words_out <= words_out + 12'h001;
      if (data_in !== first_out) begin
        same_out <= 1'b0;
      end
    end
    if (line_valid_in && frame_valid_in !== 1'b1) begin
      fv_ok_out <= 1'b0;
    end
    lv_q <= line_valid_in;
  end
endmodule

// ==== sim/test_prop_readout_port.sv ====
`timescale 1ns/1ns
module test_prop_readout_port
  import prop_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic oe = 1'b0;
  logic tb_ls = 1'b0;
  logic tb_fs = 1'b0;
  logic [31:0] rdata;
  logic [9:0] col, data, pix, first;
  logic [8:0] row;
  logic data_oe_n, lv, fv, strb, err, same, fv_ok;
  logic ls_out, ls_oe_n, fs_out, fs_oe_n;
  logic [11:0] words;
  wire [9:0] bus;
  wire ls_in;
  wire fs_in;
  int err_count = 0;
  int samples_checked = 0;

  // The array model depends on the row only, so every word of a line is known.
  assign pix = {row, 1'b1};
  // Pins resolve from the enables; the far sensor pulls low when it is silent.
  assign bus = data_oe_n ? 10'hzzz : data;
  assign ls_in = ls_oe_n ? tb_ls : ls_out;
  assign fs_in = fs_oe_n ? tb_fs : fs_out;

  prop_readout_port i_dut (
    .core_clk_in(clk), .srst_in(srst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .array_col_out(col),
    .array_row_out(row), .array_pix_in(pix), .pixel_oe_in(oe), .pixel_data_out(data),
    .pixel_data_oe_n_out(data_oe_n), .line_valid_out(lv), .frame_valid_out(fv),
    .pixel_strobe_clock_out(strb), .error_out(err), .line_sync_pin_in(ls_in),
    .line_sync_pin_out(ls_out), .line_sync_pin_oe_n_out(ls_oe_n),
    .frame_sync_pin_in(fs_in), .frame_sync_pin_out(fs_out),
    .frame_sync_pin_oe_n_out(fs_oe_n)
  );

  prop_grabber i_grab (
    .strobe_in(strb), .data_in(bus), .line_valid_in(lv), .frame_valid_in(fv),
    .words_out(words), .first_out(first), .same_out(same), .fv_ok_out(fv_ok)
  );

  // Core clock at 50 MHz.
  initial begin
    forever #10 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("Checks made: %0d, mismatches: %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      err_count++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic pulse_fs();
    @(posedge clk);
    tb_fs <= 1'b1;
    repeat (4) @(posedge clk);
    tb_fs <= 1'b0;
  endtask

  task automatic t_regs();
    logic [31:0] v;
    reg_rd(REG_CTRL, v);
    chk(v, 32'h00000000, "control reset value");
    reg_rd(8'h10, v);
    chk(v, 32'h00000000, "unmapped read");
    reg_wr(REG_BLACK, 32'h000003ff);
    reg_rd(REG_BLACK, v);
    chk(v, 32'h00000000, "read-only black offset");
    chk(data_oe_n, 1'b1, "data lines off while enable is low");
  endtask

  // A second frame sync in mid-line is a stereo fault that must show on the error pin.
  task automatic t_slave();
    logic [31:0] v;
    int n;
    reg_wr(REG_CTRL, 32'h00000001);
    cyc(4);
    chk(ls_oe_n, 1'b1, "slave line sync is an input");
    chk(fs_oe_n, 1'b1, "slave frame sync is an input");
    pulse_fs();
    cyc(300);
    chk(ls_oe_n, 1'b1, "role held while streaming");
    pulse_fs();
    for (n = 0; n < 40 && err !== 1'b1; n++) cyc(1);
    chk(err, 1'b1, "error pin follows stereo fault");
    reg_rd(REG_STATUS, v);
    chk(v[STAT_ERR_BIT], 1'b1, "error flag set");
    reg_wr(REG_STATUS, 32'h00000001);
    cyc(2);
    chk(err, 1'b0, "error pin drops with the flag");
    reg_rd(REG_STATUS, v);
    chk(v[STAT_ERR_BIT], 1'b0, "error flag cleared");
  endtask

  task automatic t_oe();
    logic s;
    @(posedge clk);
    oe <= 1'b1;
    cyc(8);
    chk(data_oe_n, 1'b0, "data lines driven before release");
    @(posedge clk);
    oe <= 1'b0;
    cyc(8);
    chk(data_oe_n, 1'b1, "data lines released");
    chk(bus, 10'hzzz, "data bus floats");
    s = strb;
    cyc(1);
    chk(strb, !s, "strobe keeps running");
    chk({lv, fv}, 2'b00, "valid lines stay driven");
    @(posedge clk);
    oe <= 1'b1;
    cyc(8);
    chk(data_oe_n, 1'b0, "data lines driven");
  endtask

  // Raw mode shows black rows 2 to 5 first; each row carries its own word.
  task automatic t_frame();
    int n;
    logic [8:0] r;
    for (n = 0; n < 80000 && fs_out !== 1'b1; n++) cyc(1);
    chk(fs_out, 1'b1, "master frame sync pulse");
    chk(ls_out, 1'b1, "master line sync at frame start");
    chk(fs_in, 1'b1, "frame sync pin carries the pulse");
    cyc(2);
    chk(fs_out, 1'b0, "frame sync pulse ends");
    for (r = RAW_FIRST; r <= RAW_LAST; r++) begin
      for (n = 0; n < 6000 && lv !== 1'b1; n++) cyc(1);
      chk(fv, 1'b1, "frame valid around line");
      for (n = 0; n < 2000 && lv !== 1'b0; n++) cyc(1);
      chk(words, OUT_COLS, "words per line");
      chk(first, {r, 1'b1}, "black row word");
      chk(same, 1'b1, "word steady at strobe rise");
      chk(fv_ok, 1'b1, "frame valid with every word");
    end
  endtask

  // Main sequence: slave fault first, then a fresh reset into master raw streaming.
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_slave();
    @(posedge clk);
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    reg_wr(REG_CTRL, 32'h0000000b);
    cyc(4);
    chk(ls_oe_n, 1'b0, "master drives line sync");
    chk(fs_oe_n, 1'b0, "master drives frame sync");
    t_oe();
    t_frame();
    tally_and_finish();
  end

  // The run needs about 1.7 ms; this margin cuts a hang short.
  initial begin
    #2200000;
    err_count++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    tally_and_finish();
  end
endmodule
